//--- src/cpad_map.svh
`ifndef CPAD_MAP_SVH
`define CPAD_MAP_SVH
`define CPAD_PORT_STRAP0 16'h002E
`define CPAD_PORT_STRAP1 16'h004E
`define CPAD_KEY_ENTER 8'h55
`define CPAD_KEY_EXIT 8'hAA
`define CPAD_DATA_OFS 16'h0001
`define CPAD_IDX_LDN 8'h07
`define CPAD_IDX_ADDR_LOW 8'h26
`define CPAD_IDX_ADDR_HIGH 8'h27
`define CPAD_RST_BYTE 8'h00
`define CPAD_POR_WAIT 3'h7
`endif

//--- src/cpad_pkg.sv
package cpad_pkg;
   typedef enum logic [0:0] {
      CPAD_ST_RUN = 1'b0,
      CPAD_ST_CFG = 1'b1
   } cpad_state_t;
endpackage : cpad_pkg

//--- src/cpad_sync_if.sv
`timescale 1ns/1ps
interface cpad_sync_if;
   logic strap;
   logic bus_rst_n;
   modport src (output strap, output bus_rst_n);
   modport dst (input strap, input bus_rst_n);
endinterface : cpad_sync_if

//--- src/cpad_pin_sync.sv
`timescale 1ns/1ps
module cpad_pin_sync (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic strap_pin_i,
   input wire logic bus_rst_n_pin_i,
   cpad_sync_if.src out
);
   logic [1:0] strap_r;
   logic [1:0] brst_r;
   // ----------------------------------------
   // Two-stage pin synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_r <= 2'h0;
         // Idle high, so reset release shows no false bus reset
         brst_r <= 2'h3;
      end else begin
         strap_r <= {strap_r[0], strap_pin_i};
         brst_r <= {brst_r[0], bus_rst_n_pin_i};
      end
   end
   assign out.strap = strap_r[1];
   assign out.bus_rst_n = brst_r[1];
endmodule : cpad_pin_sync

//--- src/cpad_decoder.sv
`timescale 1ns/1ps
`include "cpad_map.svh"
module cpad_decoder
   import cpad_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic sysopt_strap_i,
   input wire logic host_bus_reset_n_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [15:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [7:0] reg_rdata_i,
   output logic [7:0] io_rdata_o,
   output logic io_hit_o,
   output logic cfg_mode_o,
   output logic [15:0] cfg_port_o,
   output logic [7:0] ldn_o,
   output logic [7:0] reg_index_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   output logic dev_rst_o
);
   cpad_sync_if sync ();
   cpad_state_t state_r;
   logic brst_d_r;
   logic [7:0] addr_low_r;
   logic [7:0] addr_high_r;
   logic [7:0] ldn_r;
   logic [7:0] index_r;
   logic [15:0] base;
   logic port_hit;
   logic data_hit;
   logic bus_rst_fall;
   logic soft_rst;
   logic [2:0] por_wait_r;
   logic por_load;
   logic [15:0] strap_addr;
   localparam logic [15:0] POR_BASE = `CPAD_PORT_STRAP0;

   cpad_pin_sync u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .strap_pin_i(sysopt_strap_i),
      .bus_rst_n_pin_i(host_bus_reset_n_i),
      .out(sync.src)
   );

   function automatic logic [15:0] strap_base(input logic s);
      strap_base = s ? `CPAD_PORT_STRAP1 : `CPAD_PORT_STRAP0;
   endfunction : strap_base

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign base = {addr_high_r, addr_low_r};
   assign port_hit = (io_addr_i == base);
   assign data_hit = (io_addr_i == base + `CPAD_DATA_OFS);
   assign bus_rst_fall = brst_d_r & ~sync.bus_rst_n;
   // Held bus reset keeps everything in reset, not only the edge
   assign soft_rst = ~sync.bus_rst_n;
   assign strap_addr = strap_base(sync.strap);
   assign por_load = por_wait_r[2];

   // ----------------------------------------
   // Power-on strap load
   // ----------------------------------------
   // Synced strap is valid only two edges after reset, so keep loading until then
   // Strap pin is shared with a GPIO line; it is only looked at during the power-on load and while bus reset is low
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         por_wait_r <= `CPAD_POR_WAIT;
      end else begin
         por_wait_r <= {por_wait_r[1:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         brst_d_r <= 1'b1;
      end else begin
         brst_d_r <= sync.bus_rst_n;
      end
   end

   // ----------------------------------------
   // Run / Configuration state
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= CPAD_ST_RUN;
      end else if (soft_rst) begin
         state_r <= CPAD_ST_RUN;
      end else if (io_wr_i && port_hit) begin
         case (state_r)
            CPAD_ST_RUN: begin
               if (io_wdata_i == `CPAD_KEY_ENTER) begin
                  state_r <= CPAD_ST_CFG;
               end
            end
            CPAD_ST_CFG: begin
               if (io_wdata_i == `CPAD_KEY_EXIT) begin
                  state_r <= CPAD_ST_RUN;
               end
            end
            default: begin
               state_r <= CPAD_ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Port base address registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_low_r <= POR_BASE[7:0];
         addr_high_r <= POR_BASE[15:8];
      end else if (bus_rst_fall || soft_rst || por_load) begin
         addr_low_r <= strap_addr[7:0];
         addr_high_r <= strap_addr[15:8];
      end else if (io_wr_i && data_hit && state_r == CPAD_ST_CFG) begin
         if (index_r == `CPAD_IDX_ADDR_LOW) begin
            addr_low_r <= io_wdata_i;
         end
         if (index_r == `CPAD_IDX_ADDR_HIGH) begin
            addr_high_r <= io_wdata_i;
         end
      end
   end

   // ----------------------------------------
   // Index and logical device number
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         index_r <= `CPAD_RST_BYTE;
         ldn_r <= `CPAD_RST_BYTE;
      end else if (soft_rst) begin
         index_r <= `CPAD_RST_BYTE;
         ldn_r <= `CPAD_RST_BYTE;
      end else if (io_wr_i && state_r == CPAD_ST_CFG) begin
         // Index port write
         // Exit key never lands in the index
         if (port_hit && io_wdata_i != `CPAD_KEY_EXIT) begin
            index_r <= io_wdata_i;
         end
         if (data_hit && index_r == `CPAD_IDX_LDN) begin
            ldn_r <= io_wdata_i;
         end
      end
   end

   // ----------------------------------------
   // Host side outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         io_rdata_o <= `CPAD_RST_BYTE;
         io_hit_o <= 1'b0;
         reg_wr_o <= 1'b0;
         reg_rd_o <= 1'b0;
         reg_wdata_o <= `CPAD_RST_BYTE;
      end else begin
         io_hit_o <= (state_r == CPAD_ST_CFG) && (io_wr_i || io_rd_i) && (port_hit || data_hit);
         reg_wr_o <= (state_r == CPAD_ST_CFG) && io_wr_i && data_hit && !soft_rst;
         reg_rd_o <= (state_r == CPAD_ST_CFG) && io_rd_i && data_hit && !soft_rst;
         reg_wdata_o <= io_wdata_i;
         if (state_r == CPAD_ST_CFG && io_rd_i && port_hit) begin
            io_rdata_o <= index_r;
         end else if (state_r == CPAD_ST_CFG && io_rd_i && data_hit) begin
            case (index_r)
               `CPAD_IDX_LDN: io_rdata_o <= ldn_r;
               `CPAD_IDX_ADDR_LOW: io_rdata_o <= addr_low_r;
               `CPAD_IDX_ADDR_HIGH: io_rdata_o <= addr_high_r;
               default: io_rdata_o <= reg_rdata_i;
            endcase
         end else begin
            io_rdata_o <= `CPAD_RST_BYTE;
         end
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_mode_o <= 1'b0;
         cfg_port_o <= `CPAD_PORT_STRAP0;
         ldn_o <= `CPAD_RST_BYTE;
         reg_index_o <= `CPAD_RST_BYTE;
         dev_rst_o <= 1'b1;
      end else begin
         cfg_mode_o <= (state_r == CPAD_ST_CFG);
         cfg_port_o <= base;
         ldn_o <= ldn_r;
         reg_index_o <= index_r;
         dev_rst_o <= soft_rst;
      end
   end
endmodule : cpad_decoder

//--- testbench/cpad_decoder_props.sv
`timescale 1ns/1ps
`include "cpad_map.svh"
module cpad_decoder_props (
   input wire logic core_clk_i, rst_i, sysopt_strap_i, host_bus_reset_n_i, io_wr_i, io_rd_i, io_hit_o,
   input wire logic cfg_mode_o, reg_wr_o,
   input wire logic reg_rd_o,
   input wire logic [15:0] io_addr_i, cfg_port_o,
   input wire logic [7:0] io_wdata_i, io_rdata_o, reg_index_o, reg_wdata_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic wq;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) wq <= 1'b0;
      else wq <= io_wr_i;
   end
   // Write after idle: state and mode flag agree then
   wire logic iw = io_wr_i && !wq && host_bus_reset_n_i;
   wire logic ai = io_addr_i == cfg_port_o;
   AST_POR: assert property ($fell(rst_i) |-> !cfg_mode_o && cfg_port_o == `CPAD_PORT_STRAP0)
      else $error("reset state");
   AST_STRAP: assert property ((!host_bus_reset_n_i && $stable(sysopt_strap_i)) [*7] |->
      cfg_port_o == (sysopt_strap_i ? `CPAD_PORT_STRAP1 : `CPAD_PORT_STRAP0)) else $error("strap base");
   AST_RUN: assert property ((io_wr_i || io_rd_i) && !cfg_mode_o && !wq |=> !io_hit_o && io_rdata_o == 8'h00)
      else $error("run claim");
   AST_ENTER: assert property (iw && !cfg_mode_o && ai && io_wdata_i == `CPAD_KEY_ENTER |-> ##2 cfg_mode_o)
      else $error("no entry");
   AST_IGNORE: assert property (iw && !cfg_mode_o && io_wdata_i != `CPAD_KEY_ENTER |-> ##2 !cfg_mode_o)
      else $error("bad entry");
   AST_EXIT: assert property (io_wr_i && cfg_mode_o && ai && io_wdata_i == `CPAD_KEY_EXIT |-> ##2 !cfg_mode_o)
      else $error("no exit");
   AST_DATA: assert property (iw && cfg_mode_o && io_addr_i == cfg_port_o + `CPAD_DATA_OFS |=>
      reg_wr_o && io_hit_o && reg_wdata_o == $past(io_wdata_i)) else $error("data write");
   AST_INDEX: assert property (iw && cfg_mode_o && ai && io_wdata_i != `CPAD_KEY_EXIT |=>
      io_hit_o ##1 reg_index_o == $past(io_wdata_i, 2)) else $error("index load");
   AST_RDSTB: assert property (io_rd_i && !wq && cfg_mode_o && io_addr_i == cfg_port_o + `CPAD_DATA_OFS |=>
      reg_rd_o && io_hit_o) else $error("data read");
   COV_ENTER: cover property ($rose(cfg_mode_o));
   COV_WR: cover property (reg_wr_o);
   COV_EXIT: cover property ($fell(cfg_mode_o));
endmodule : cpad_decoder_props
bind cpad_decoder cpad_decoder_props cpad_decoder_props_inst (.*);

//--- testbench/cpad_host_model.sv
`timescale 1ns/1ps
module cpad_host_model (
   input wire logic core_clk_i,
   input wire logic [7:0] io_rdata_i,
   input wire logic io_hit_i,
   output logic io_wr_o = 1'b0,
   output logic io_rd_o = 1'b0,
   output logic [15:0] io_addr_o = 16'h0000,
   output logic [7:0] io_wdata_o = 8'h00
);
   logic [7:0] rd_data;
   logic rd_hit;
   task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      io_wr_o <= w;
      io_rd_o <= !w;
      io_addr_o <= a;
      io_wdata_o <= d;
      @(posedge core_clk_i);
      io_wr_o <= 1'b0;
      io_rd_o <= 1'b0;
      // Released lines flip so stale values never match
      io_addr_o <= ~a;
      io_wdata_o <= ~d;
      #1;
      rd_data = io_rdata_i;
      rd_hit = io_hit_i;
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask : cycle
endmodule : cpad_host_model

//--- testbench/tb_config_port_access_decoder.sv
`timescale 1ns/1ps
module tb_config_port_access_decoder;
   logic core_clk_i = 1'b0, rst_i = 1'b1, sysopt_strap_i = 1'b0, host_bus_reset_n_i = 1'b1;
   logic [7:0] reg_rdata_i = 8'hC3;
   wire logic io_wr_i, io_rd_i, io_hit_o, cfg_mode_o, dev_rst_o;
   wire logic [15:0] io_addr_i, cfg_port_o;
   wire logic [7:0] io_wdata_i, io_rdata_o, ldn_o, reg_index_o;
   int num_errors = 0, check_count = 0, cycles = 0;
   cpad_decoder cpad_decoder_inst (.*, .reg_wr_o(), .reg_rd_o(), .reg_wdata_o());
   cpad_host_model cpad_host_model_inst (.core_clk_i(core_clk_i), .io_rdata_i(io_rdata_o), .io_hit_i(io_hit_o),
      .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i));
   wire logic [8:0] seen = {cpad_host_model_inst.rd_hit, cpad_host_model_inst.rd_data};
   initial forever #2.5 core_clk_i = ~core_clk_i;
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("%0d checks, %0d errors", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
      cpad_host_model_inst.cycle(w, a, d);
   endtask : io
   task automatic brst(input logic s);
      @(posedge core_clk_i);
      sysopt_strap_i <= s;
      host_bus_reset_n_i <= 1'b0;
      repeat (7) @(posedge core_clk_i);
      #1;
      check(dev_rst_o, 1'b1);
      @(posedge core_clk_i);
      host_bus_reset_n_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1;
   endtask : brst
   task automatic t_reset();
      check({cfg_mode_o, cfg_port_o}, 17'h0002E);
      brst(1'b1);
      check(cfg_port_o, 16'h004E);
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      #1;
      check(cfg_port_o, 16'h004E);
      brst(1'b0);
      check(cfg_port_o, 16'h002E);
      check(dev_rst_o, 1'b0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_run();
      io(1'b1, 16'h002E, 8'h07);
      io(1'b0, 16'h002F, 8'h00);
      check(seen, 9'h000);
      check({cfg_mode_o, reg_index_o}, 9'h000);
      $display("run test done");
   endtask : t_run
   task automatic t_cfg();
      io(1'b1, 16'h002E, 8'h55);
      check(cfg_mode_o, 1'b1);
      io(1'b1, 16'h002E, 8'h07);
      io(1'b1, 16'h002F, 8'h08);
      check({seen[8], ldn_o}, 9'h108);
      io(1'b0, 16'h002F, 8'h00);
      check(seen, 9'h108);
      io(1'b1, 16'h002E, 8'h30);
      io(1'b0, 16'h002F, 8'h00);
      check(seen, 9'h1C3);
      io(1'b1, 16'h002E, 8'hAA);
      check(cfg_mode_o, 1'b0);
      $display("config test done");
   endtask : t_cfg
   task automatic t_reloc();
      io(1'b1, 16'h002E, 8'h55);
      io(1'b1, 16'h002E, 8'h26);
      io(1'b1, 16'h002F, 8'h70);
      io(1'b1, 16'h0070, 8'h27);
      io(1'b1, 16'h0071, 8'h01);
      check(cfg_port_o, 16'h0170);
      io(1'b1, 16'h0170, 8'hAA);
      io(1'b1, 16'h002E, 8'h55);
      check(cfg_mode_o, 1'b0);
      io(1'b1, 16'h0170, 8'h55);
      check(cfg_mode_o, 1'b1);
      $display("relocate test done");
   endtask : t_reloc
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      t_reset();
      t_run();
      t_cfg();
      t_reloc();
      give_verdict();
   end
endmodule : tb_config_port_access_decoder
